// ### core/pbd_defs.svh
// register offsets, field positions, reset values and widths of the buffer dma engine
// assumes a 32-bit classic wishbone slave with byte addresses, one register per word
`ifndef PBD_DEFS_SVH
`define PBD_DEFS_SVH
// buffer address width and checksum width
`define PBD_AW 13
`define PBD_CSW 16
// register byte offsets
`define PBD_OFS_IRQ_EN 8'h00
`define PBD_OFS_IRQ_FLAGS 8'h04
`define PBD_OFS_CTRL 8'h08
`define PBD_OFS_RXEND_LO 8'h0C
`define PBD_OFS_RXEND_HI 8'h10
`define PBD_OFS_RXSTART_LO 8'h14
`define PBD_OFS_RXSTART_HI 8'h18
`define PBD_OFS_SRCSTART_LO 8'h1C
`define PBD_OFS_SRCSTART_HI 8'h20
`define PBD_OFS_SRCEND_LO 8'h24
`define PBD_OFS_SRCEND_HI 8'h28
`define PBD_OFS_DST_LO 8'h2C
`define PBD_OFS_DST_HI 8'h30
`define PBD_OFS_CSUM_LO 8'h34
`define PBD_OFS_CSUM_HI 8'h38
// control register bit positions
`define PBD_CTRL_TRANSMIT_RESET 7
`define PBD_CTRL_RECEIVE_RESET 6
`define PBD_CTRL_START 5
`define PBD_CTRL_CSUM 4
`define PBD_CTRL_TXRQ 3
`define PBD_CTRL_RXEN 2
// interrupt enable and flag bit positions
`define PBD_IE_GLOBAL 7
`define PBD_IRQ_DMA 5
// reset values and checksum pad byte
`define PBD_RST_BYTE 8'h00
`define PBD_RST_PTR 13'h0000
`define PBD_RST_CSUM 16'h0000
`define PBD_PAD_BYTE 8'h00
`endif

// ### core/pbd_pkg.sv
// types of the packet buffer dma and checksum engine
// assumes pbd_defs.svh on the include path
`include "pbd_defs.svh"
package pbd_pkg;
    // engine sequence
    typedef enum logic [1:0] {
        PBD_IDLE,
        PBD_WAIT_TX,
        PBD_RUN,
        PBD_DRAIN
    } pbd_state_type;
    // classic wishbone request and answer
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } pbd_wb_req_type;
    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } pbd_wb_rsp_type;
    // one receive byte bound for the buffer
    typedef struct packed {
        logic valid;
        logic [`PBD_AW-1:0] addr;
        logic [7:0] data;
    } pbd_rx_wr_type;
    // whole register state of the engine
    typedef struct packed {
        pbd_state_type st;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] ie;
        logic flag;
        logic transmit_reset;
        logic receive_reset;
        logic csum;
        logic txrq;
        logic rxen;
        logic [`PBD_AW-1:0] rx_end;
        logic [`PBD_AW-1:0] rx_start;
        logic [`PBD_AW-1:0] start;
        logic [`PBD_AW-1:0] stop;
        logic [`PBD_AW-1:0] dst;
        logic [`PBD_AW-1:0] src;
        logic [`PBD_AW-1:0] dsti;
        logic [`PBD_CSW-1:0] cs;
        logic [`PBD_CSW-1:0] acc;
        logic [7:0] hi;
        logic odd;
        logic vld;
    } pbd_regs_type;
endpackage

// ### core/pbd_dma_checksum.sv
// packet buffer with byte-serial copy and internet checksum engine
// assumes a classic wishbone master, a receive writer and a transmit reader on one clock
//
// Functional notes
// - copy destination advances linearly, wraps at top
// - start waits while transmit request is pending
// - copy end clears busy, sets flag, keeps pointers
// - one byte moved per cycle when unstalled
// - receive byte write stalls engine that cycle
// - checksum words big endian, first byte high
// - odd count pads final low byte zero
// - end-around sum, result stored complemented
// - checksum end: busy clear, flag, no writes
// - checksum takes one cycle per byte
// - checksum waits for transmit request clear
// - pointers 13 bits, high byte five bits
// - transmit reset holds transmit logic only
// - reset sets registers, buffer left undefined
// - source reloads ring start at ring end
// - start copied to internal pointer, ends at end
// - clearing start aborts at once, registers kept
module pbd_dma_checksum
    import pbd_pkg::*;
#(
    parameter int ADDR_W = `PBD_AW
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // register bus
    input wire pbd_wb_req_type wb_req_i,
    output pbd_wb_rsp_type wb_rsp_o,
    // receive hardware write port, wins the buffer
    input wire pbd_rx_wr_type rx_wr_i,
    // transmit engine side and receive controls
    input wire logic tx_done_i,
    input wire logic [ADDR_W-1:0] tx_rd_addr_i,
    output logic [7:0] tx_rd_data_o,
    output logic transmit_request_o,
    output logic transmit_reset_o,
    output logic receive_reset_o,
    output logic rx_enable_o,
    // interrupt request and busy state
    output logic dma_irq_o,
    output logic op_start_busy_o
);

    // elaboration check: the register layout serves only the documented width
    if (ADDR_W != `PBD_AW) begin : g_bad_width
        $error("pbd_dma_checksum: ADDR_W must equal the 13-bit pointer width");
    end

    // one's complement add with end-around carry
    function automatic logic [15:0] f_oc_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] t;
        t = {1'b0, a} + {1'b0, b};
        return 16'(t[15:0] + {15'h0000, t[16]});
    endfunction

    // register read decode, narrow values in the low bits
    function automatic logic [31:0] f_read(input pbd_regs_type r, input logic [7:0] adr);
        logic [7:0] b;
        b = `PBD_RST_BYTE;
        case (adr)
            `PBD_OFS_IRQ_EN: b = r.ie;
            `PBD_OFS_IRQ_FLAGS: b = {2'b00, r.flag, 5'b00000};
            `PBD_OFS_CTRL: b = {r.transmit_reset, r.receive_reset, (r.st != PBD_IDLE), r.csum, r.txrq, r.rxen,
                2'b00};
            `PBD_OFS_RXEND_LO: b = r.rx_end[7:0];
            `PBD_OFS_RXEND_HI: b = {3'b000, r.rx_end[12:8]};
            `PBD_OFS_RXSTART_LO: b = r.rx_start[7:0];
            `PBD_OFS_RXSTART_HI: b = {3'b000, r.rx_start[12:8]};
            `PBD_OFS_SRCSTART_LO: b = r.start[7:0];
            `PBD_OFS_SRCSTART_HI: b = {3'b000, r.start[12:8]};
            `PBD_OFS_SRCEND_LO: b = r.stop[7:0];
            `PBD_OFS_SRCEND_HI: b = {3'b000, r.stop[12:8]};
            `PBD_OFS_DST_LO: b = r.dst[7:0];
            `PBD_OFS_DST_HI: b = {3'b000, r.dst[12:8]};
            `PBD_OFS_CSUM_LO: b = r.cs[7:0];
            `PBD_OFS_CSUM_HI: b = r.cs[15:8];
            default: b = `PBD_RST_BYTE;
        endcase
        return {24'h00_0000, b};
    endfunction

    pbd_regs_type q, s;
    logic [7:0] mem [0:(1<<`PBD_AW)-1];
    logic [7:0] mem_rdata_q;
    logic [7:0] tx_rdata_q;
    logic acc_go;
    logic wr_go;
    logic rd_issue;
    logic consume;
    logic eng_we;
    logic fin;
    logic ctrl_wr;
    logic [7:0] wd;

    // next-state logic for bus, control and engine
    always_comb begin
        s = q;
        fin = 1'b0;
        eng_we = 1'b0;
        rd_issue = 1'b0;
        consume = 1'b0;
        acc_go = wb_req_i.cyc && wb_req_i.stb && !q.ack;
        wr_go = acc_go && wb_req_i.we && wb_req_i.sel[0];
        ctrl_wr = wr_go && (wb_req_i.adr == `PBD_OFS_CTRL);
        wd = wb_req_i.dat[7:0];
        s.ack = acc_go;
        s.rdat = (acc_go && !wb_req_i.we) ? f_read(q, wb_req_i.adr) : 32'h0000_0000;
        // transmit engine clears its request when done or held in reset
        if (tx_done_i || q.transmit_reset) begin
            s.txrq = 1'b0;
        end
        // software register writes
        if (wr_go) begin
            case (wb_req_i.adr)
                `PBD_OFS_IRQ_EN: s.ie = wd;
                `PBD_OFS_IRQ_FLAGS: s.flag = wd[`PBD_IRQ_DMA];
                `PBD_OFS_CTRL: begin
                    s.transmit_reset = wd[`PBD_CTRL_TRANSMIT_RESET];
                    s.receive_reset = wd[`PBD_CTRL_RECEIVE_RESET];
                    s.csum = wd[`PBD_CTRL_CSUM];
                    s.txrq = wd[`PBD_CTRL_TXRQ] && !wd[`PBD_CTRL_TRANSMIT_RESET];
                    s.rxen = wd[`PBD_CTRL_RXEN];
                    if (wd[`PBD_CTRL_START] && q.st == PBD_IDLE) begin
                        s.st = PBD_WAIT_TX;
                    end else if (!wd[`PBD_CTRL_START] && q.st != PBD_IDLE) begin
                        s.st = PBD_IDLE;
                        s.vld = 1'b0;
                    end
                end
                `PBD_OFS_RXEND_LO: s.rx_end[7:0] = wd;
                `PBD_OFS_RXEND_HI: s.rx_end[12:8] = wd[4:0];
                `PBD_OFS_RXSTART_LO: s.rx_start[7:0] = wd;
                `PBD_OFS_RXSTART_HI: s.rx_start[12:8] = wd[4:0];
                `PBD_OFS_SRCSTART_LO: s.start[7:0] = wd;
                `PBD_OFS_SRCSTART_HI: s.start[12:8] = wd[4:0];
                `PBD_OFS_SRCEND_LO: s.stop[7:0] = wd;
                `PBD_OFS_SRCEND_HI: s.stop[12:8] = wd[4:0];
                `PBD_OFS_DST_LO: s.dst[7:0] = wd;
                `PBD_OFS_DST_HI: s.dst[12:8] = wd[4:0];
                `PBD_OFS_CSUM_LO: s.cs[7:0] = wd;
                `PBD_OFS_CSUM_HI: s.cs[15:8] = wd;
                default: s.rdat = s.rdat;
            endcase
        end
        // engine, skipped when aborted in this cycle
        if (s.st != PBD_IDLE) begin
            // byte read last cycle is consumed unless receive holds the buffer
            consume = q.vld && !rx_wr_i.valid;
            if (consume) begin
                if (q.csum) begin
                    if (!q.odd) begin
                        s.hi = mem_rdata_q;
                        s.odd = 1'b1;
                    end else begin
                        s.acc = f_oc_add(q.acc, {q.hi, mem_rdata_q});
                        s.odd = 1'b0;
                    end
                end else begin
                    eng_we = 1'b1;
                    s.dsti = ADDR_W'(q.dsti + 1'b1);
                end
            end
            case (q.st)
                PBD_WAIT_TX: begin
                    if (!q.txrq) begin
                        s.st = PBD_RUN;
                        s.src = q.start;
                        s.dsti = q.dst;
                        s.acc = `PBD_RST_CSUM;
                        s.odd = 1'b0;
                    end
                end
                PBD_RUN: begin
                    rd_issue = !rx_wr_i.valid;
                    if (rd_issue) begin
                        if (q.src == q.stop) begin
                            s.st = PBD_DRAIN;
                        end else if (q.src == q.rx_end) begin
                            s.src = q.rx_start;
                        end else begin
                            s.src = ADDR_W'(q.src + 1'b1);
                        end
                    end
                end
                PBD_DRAIN: begin
                    if (!q.vld) begin
                        s.st = PBD_IDLE;
                        fin = 1'b1;
                        if (q.csum) begin
                            s.cs = q.odd ? ~f_oc_add(q.acc, {q.hi, `PBD_PAD_BYTE})
                                : ~q.acc;
                        end
                    end
                end
                default: s.st = s.st;
            endcase
            s.vld = rd_issue ? 1'b1 : (consume ? 1'b0 : q.vld);
        end
        // completion sets the flag, winning over a clear in the same cycle
        if (fin) begin
            s.flag = 1'b1;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
        end else begin
            q <= s;
        end
    end

    // buffer memory, not reset; receive writes win over the engine
    always_ff @(posedge clk_i) begin
        if (rx_wr_i.valid) begin
            mem[rx_wr_i.addr] <= rx_wr_i.data;
        end else if (eng_we) begin
            mem[q.dsti] <= mem_rdata_q;
        end
        if (rd_issue) begin
            mem_rdata_q <= mem[q.src];
        end
        tx_rdata_q <= mem[tx_rd_addr_i];
    end

    // outputs
    assign wb_rsp_o.ack = q.ack;
    assign wb_rsp_o.dat = q.rdat;
    assign tx_rd_data_o = tx_rdata_q;
    assign transmit_request_o = q.txrq;
    assign transmit_reset_o = q.transmit_reset;
    assign receive_reset_o = q.receive_reset;
    assign rx_enable_o = q.rxen;
    assign op_start_busy_o = (q.st != PBD_IDLE);
    assign dma_irq_o = q.flag && q.ie[`PBD_IRQ_DMA] && q.ie[`PBD_IE_GLOBAL];

    // checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence s_finish;
        fin;
    endsequence
    sequence s_done_state;
        q.flag && q.st == PBD_IDLE;
    endsequence

    property p_done_flag;
        s_finish |=> s_done_state;
    endproperty
    a_done_flag: assert property (p_done_flag) else $error("finish did not set flag");

    property p_tx_hold;
        (q.st == PBD_WAIT_TX && q.txrq && !tx_done_i) |=> q.st != PBD_RUN;
    endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("ran under transmit request");

    property p_rx_stall;
        rx_wr_i.valid |-> !rd_issue && !eng_we;
    endproperty
    a_rx_stall: assert property (p_rx_stall) else $error("engine used buffer during rx");

    property p_src_step;
        (q.st == PBD_RUN && !rx_wr_i.valid && q.src != q.stop && !ctrl_wr) |=>
            q.src == ($past(q.src) == $past(q.rx_end) ? $past(q.rx_start)
                : ADDR_W'($past(q.src) + 1'b1));
    endproperty
    a_src_step: assert property (p_src_step) else $error("source pointer step wrong");

    property p_dst_step;
        eng_we |=> q.dsti == ADDR_W'($past(q.dsti) + 1'b1);
    endproperty
    a_dst_step: assert property (p_dst_step) else $error("destination step wrong");

    property p_csum_nowrite;
        q.csum |-> !eng_we;
    endproperty
    a_csum_nowrite: assert property (p_csum_nowrite) else $error("checksum wrote memory");

    property p_launch;
        (q.st == PBD_WAIT_TX && !q.txrq && !ctrl_wr) |=>
            q.st == PBD_RUN && q.src == $past(q.start);
    endproperty
    a_launch: assert property (p_launch) else $error("launch did not load source");

    property p_abort;
        (ctrl_wr && !wd[`PBD_CTRL_START] && q.st != PBD_IDLE) |=>
            q.st == PBD_IDLE && q.flag == $past(q.flag) && q.cs == $past(q.cs);
    endproperty
    a_abort: assert property (p_abort) else $error("abort changed registers");

    property p_irq;
        (dma_irq_o && !wr_go) |=> dma_irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("irq dropped without a write");

    property p_transmit_reset;
        transmit_reset_o |=> !transmit_request_o;
    endproperty
    a_transmit_reset: assert property (p_transmit_reset) else $error("request survived transmit reset");

    // a start write while idle always passes through the transmit wait
    property p_start_waits;
        (ctrl_wr && wd[`PBD_CTRL_START] && q.st == PBD_IDLE) |=> q.st == PBD_WAIT_TX;
    endproperty
    a_start_waits: assert property (p_start_waits) else $error("start skipped wait");

    // an unstalled running cycle always fetches the next byte
    property p_fetch;
        (q.st == PBD_RUN && !rx_wr_i.valid && !ctrl_wr) |=> q.vld;
    endproperty
    a_fetch: assert property (p_fetch) else $error("running cycle fetched no byte");

    // a receive write freezes the source walk for that cycle
    property p_rx_hold_src;
        (q.st == PBD_RUN && rx_wr_i.valid && !ctrl_wr) |=> q.st == PBD_RUN && q.src == $past(q.src);
    endproperty
    a_rx_hold_src: assert property (p_rx_hold_src) else $error("source moved during rx");

    // the last byte is fetched when the internal pointer meets the end
    property p_end_match;
        (q.st == PBD_RUN && q.src == q.stop && !rx_wr_i.valid && !ctrl_wr) |=>
            q.st == PBD_DRAIN;
    endproperty
    a_end_match: assert property (p_end_match) else $error("end pointer match missed");

    // engine retiring from drain with no software write on the bus
    sequence s_retire;
        q.st == PBD_DRAIN && !q.vld && !wr_go;
    endsequence

    sequence s_copy_retire;
        q.st == PBD_DRAIN && !q.vld && !wr_go && !q.csum;
    endsequence

    sequence s_even_retire;
        q.st == PBD_DRAIN && !q.vld && !wr_go && q.csum && !q.odd;
    endsequence

    // completion leaves the source start, source end and destination pointers where they were
    property p_keep_ptrs;
        s_retire |=> q.start == $past(q.start) && q.stop == $past(q.stop)
            && q.dst == $past(q.dst);
    endproperty
    a_keep_ptrs: assert property (p_keep_ptrs) else $error("completion moved a pointer");

    // a copy never touches the checksum result
    property p_copy_keeps_sum;
        s_copy_retire |=> q.cs == $past(q.cs);
    endproperty
    a_copy_keeps_sum: assert property (p_copy_keeps_sum) else $error("copy changed checksum");

    // an even range stores the plain complement of the running sum
    property p_even_result;
        s_even_retire |=> q.cs == ~$past(q.acc);
    endproperty
    a_even_result: assert property (p_even_result) else $error("sum not complemented");

    // the done flag only falls on a software write to the flag register
    property p_flag_sticky;
        (q.flag && !(wr_go && wb_req_i.adr == `PBD_OFS_IRQ_FLAGS)) |=> q.flag;
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("done flag dropped");

    // transmit reset stays until software writes the control register
    property p_transmit_reset_hold;
        (transmit_reset_o && !ctrl_wr) |=> transmit_reset_o;
    endproperty
    a_transmit_reset_hold: assert property (p_transmit_reset_hold) else $error("transmit reset let go");

endmodule

// ### dv/pbd_dma_checksum_tb.sv
// self-checking bench of the buffer dma and checksum engine
// assumes pbd_pkg compiled first and pbd_defs.svh on the include path
`include "pbd_defs.svh"
module packet_buffer_dma_checksum_tb_top
    import pbd_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    pbd_wb_req_type req = '0;
    pbd_wb_rsp_type rsp;
    pbd_rx_wr_type rx = '0;
    logic tx_done = 1'b0;
    logic [12:0] tx_addr = 13'h0000;
    logic [7:0] tx_data;
    logic txrq, transmit_reset, receive_reset, rxen, irq, busy;
    int n_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    logic [31:0] rng = 32'h0000_a004;
    logic [31:0] expq[$];
    logic [7:0] bytes[$];

    // 200 MHz clock
    always #2.5 clk_i = ~clk_i;

    pbd_dma_checksum pbd_dma_checksum_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req), .wb_rsp_o(rsp), .rx_wr_i(rx),
        .tx_done_i(tx_done), .tx_rd_addr_i(tx_addr), .tx_rd_data_o(tx_data),
        .transmit_request_o(txrq), .transmit_reset_o(transmit_reset), .receive_reset_o(receive_reset),
        .rx_enable_o(rxen), .dma_irq_o(irq), .op_start_busy_o(busy)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // hang guard, far above the under one thousand cycles the tests need
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            test_done();
        end
    end

    // read answers are compared against the oldest noted expectation
    always @(negedge clk_i) begin
        if (rsp.ack === 1'b1 && req.we === 1'b0 && expq.size() > 0) begin
            chk(rsp.dat, expq.pop_front());
        end
    end

    function automatic logic [7:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[7:0];
    endfunction

    // one classic wishbone cycle, held until ack is seen high
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        req <= '{1'b1, 1'b1, we, a, 4'h1, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (rsp.ack !== 1'b1 && n < 40);
        req <= '0;
        if (n >= 40) chk(32'h0000_0001, 32'h0000_0000);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wb(1'b1, a, {24'h00_0000, d});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        wb(1'b0, a, 32'h0000_0000);
    endtask

    task automatic ptrs(input logic [12:0] s, input logic [12:0] e, input logic [12:0] d);
        wr(`PBD_OFS_SRCSTART_LO, s[7:0]);
        wr(`PBD_OFS_SRCSTART_HI, {3'h0, s[12:8]});
        wr(`PBD_OFS_SRCEND_LO, e[7:0]);
        wr(`PBD_OFS_SRCEND_HI, {3'h0, e[12:8]});
        wr(`PBD_OFS_DST_LO, d[7:0]);
        wr(`PBD_OFS_DST_HI, {3'h0, d[12:8]});
    endtask

    // receive writes on consecutive cycles, valid held high throughout
    task automatic fill(input logic [12:0] base, input int first, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            rx <= '{1'b1, base + 13'(i), bytes[first+i]};
        end
        @(posedge clk_i);
        rx <= '0;
    endtask

    // unrelated receive traffic that steals buffer cycles from the engine
    task automatic stall();
        repeat (4) begin
            @(posedge clk_i);
            rx <= '{1'b1, 13'h0800, rnd()};
        end
        @(posedge clk_i);
        rx <= '0;
    endtask

    task automatic bufchk(input logic [12:0] a, input logic [7:0] e);
        @(posedge clk_i);
        tx_addr <= a;
        @(posedge clk_i);
        @(negedge clk_i);
        chk({24'h00_0000, tx_data}, {24'h00_0000, e});
    endtask

    // bounded wait for busy to fall, then the idle gap before any restart
    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            @(negedge clk_i);
            n++;
        end while (busy !== 1'b0 && n < 300);
        chk({31'h0, busy}, 32'h0000_0000);
        repeat (5) @(posedge clk_i);
    endtask

    function automatic logic [15:0] csum16(input int n);
        logic [16:0] s;
        s = 17'h0_0000;
        for (int i = 0; i < n; i += 2) begin
            s = s + {1'b0, bytes[i], (i + 1 < n) ? bytes[i+1] : 8'h00};
            s = {1'b0, s[15:0]} + {16'h0000, s[16]};
        end
        return ~s[15:0];
    endfunction

    initial begin
        logic [15:0] cs;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(`PBD_OFS_IRQ_EN, 32'h0000_0000);
        rd(`PBD_OFS_CTRL, 32'h0000_0000);
        rd(`PBD_OFS_CSUM_HI, 32'h0000_0000);
        rd(8'hFC, 32'h0000_0000);
        wr(`PBD_OFS_SRCSTART_HI, 8'hFF);
        rd(`PBD_OFS_SRCSTART_HI, 32'h0000_001F);
        wr(`PBD_OFS_RXSTART_HI, 8'h10);
        wr(`PBD_OFS_RXEND_LO, 8'hFF);
        wr(`PBD_OFS_RXEND_HI, 8'h1F);
        wr(`PBD_OFS_IRQ_EN, 8'hA0);
        $display("test registers done");
        // known odd triple, held off while a transmit is pending
        bytes = '{8'h89, 8'hAB, 8'hCD};
        fill(13'h0100, 0, 3);
        fill(13'h0000, 2, 1);
        ptrs(13'h0100, 13'h0102, 13'h0000);
        wr(`PBD_OFS_CTRL, 8'h08);
        wr(`PBD_OFS_CTRL, 8'h38);
        repeat (30) @(posedge clk_i);
        chk({31'h0, busy}, 32'h0000_0001);
        rd(`PBD_OFS_CSUM_LO, 32'h0000_0000);
        @(posedge clk_i);
        tx_done <= 1'b1;
        @(posedge clk_i);
        tx_done <= 1'b0;
        wait_idle();
        chk({31'h0, irq}, 32'h0000_0001);
        rd(`PBD_OFS_CSUM_LO, 32'h0000_0053);
        rd(`PBD_OFS_CSUM_HI, 32'h0000_00A9);
        rd(`PBD_OFS_SRCEND_LO, 32'h0000_0002);
        bufchk(13'h0000, 8'hCD);
        wr(`PBD_OFS_IRQ_FLAGS, 8'h00);
        chk({31'h0, irq}, 32'h0000_0000);
        $display("test checksum with transmit wait done");
        // random odd range with receive traffic stealing cycles
        bytes = {};
        repeat (7) bytes.push_back(rnd());
        fill(13'h0300, 0, 7);
        cs = csum16(7);
        ptrs(13'h0300, 13'h0306, 13'h0000);
        wr(`PBD_OFS_CTRL, 8'h30);
        stall();
        wait_idle();
        rd(`PBD_OFS_CSUM_LO, {24'h00_0000, cs[7:0]});
        rd(`PBD_OFS_CSUM_HI, {24'h00_0000, cs[15:8]});
        wr(`PBD_OFS_IRQ_FLAGS, 8'h00);
        // even range over the same bytes, no padding byte
        cs = csum16(6);
        ptrs(13'h0300, 13'h0305, 13'h0000);
        wr(`PBD_OFS_CTRL, 8'h30);
        wait_idle();
        rd(`PBD_OFS_CSUM_LO, {24'h00_0000, cs[7:0]});
        rd(`PBD_OFS_CSUM_HI, {24'h00_0000, cs[15:8]});
        wr(`PBD_OFS_IRQ_FLAGS, 8'h00);
        $display("test random checksum done");
        // copy through the ring end with a destination wrapping at the top
        bytes = {};
        repeat (3) bytes.push_back(rnd());
        fill(13'h1FFE, 0, 2);
        fill(13'h1000, 2, 1);
        ptrs(13'h1FFE, 13'h1000, 13'h1FFF);
        wr(`PBD_OFS_CTRL, 8'h20);
        stall();
        wait_idle();
        bufchk(13'h1FFF, bytes[0]);
        bufchk(13'h0000, bytes[1]);
        bufchk(13'h0001, bytes[2]);
        rd(`PBD_OFS_IRQ_FLAGS, 32'h0000_0020);
        rd(`PBD_OFS_DST_HI, 32'h0000_001F);
        rd(`PBD_OFS_CSUM_HI, {24'h00_0000, cs[15:8]});
        wr(`PBD_OFS_IRQ_FLAGS, 8'h00);
        $display("test copy done");
        // abort of a waiting copy leaves flag and registers alone
        wr(`PBD_OFS_CTRL, 8'h08);
        wr(`PBD_OFS_CTRL, 8'h28);
        wr(`PBD_OFS_CTRL, 8'h08);
        chk({31'h0, busy}, 32'h0000_0000);
        rd(`PBD_OFS_IRQ_FLAGS, 32'h0000_0000);
        rd(`PBD_OFS_SRCSTART_LO, 32'h0000_00FE);
        $display("test abort done");
        // transmit and receive reset together drop the request, keep buffer management
        wr(`PBD_OFS_CTRL, 8'hCC);
        chk({31'h0, transmit_reset}, 32'h0000_0001);
        chk({31'h0, txrq}, 32'h0000_0000);
        chk({31'h0, receive_reset}, 32'h0000_0001);
        chk({31'h0, rxen}, 32'h0000_0001);
        wr(`PBD_OFS_CTRL, 8'h00);
        repeat (330) @(posedge clk_i);
        chk({31'h0, transmit_reset}, 32'h0000_0000);
        chk({31'h0, rxen}, 32'h0000_0000);
        rd(`PBD_OFS_SRCEND_HI, 32'h0000_0010);
        $display("test transmit reset done");
        test_done();
    end
endmodule
